// ===== rtl/pcs_pkg.sv
// shared constants, layouts and types of the position counter sync interface
package pcs_pkg;

    // byte positions inside the control and feedback images
    localparam int unsigned PCS_BYTE_VALUE     = 0;  // bytes 0..3
    localparam int unsigned PCS_BYTE_CMD       = 4;  // control byte 4 / feedback byte 4
    localparam int unsigned PCS_BYTE_LOADREQ   = 5;  // control byte 5 / feedback byte 5
    localparam int unsigned PCS_BYTE_EVENT     = 6;  // feedback byte 6
    localparam int unsigned PCS_BYTE_WIDE      = 8;  // feedback bytes 8..11

    // control byte 4 bit positions
    localparam int unsigned PCS_CMD_GATE_BIT   = 0;
    localparam int unsigned PCS_CMD_SYNC_BIT   = 1;
    localparam int unsigned PCS_CMD_CLRREQ_BIT = 2;
    localparam int unsigned PCS_CMD_ERRACK_BIT = 7;

    // control byte 5 bit positions
    localparam int unsigned PCS_REQ_IMM_BIT    = 0;
    localparam int unsigned PCS_REQ_STAGED_BIT = 1;

    // feedback byte 4 bit positions
    localparam int unsigned PCS_ERR_LOADRUN_BIT = 0;
    localparam int unsigned PCS_ERR_LOADERR_BIT = 1;
    localparam int unsigned PCS_ERR_CLRACK_BIT  = 2;
    localparam int unsigned PCS_ERR_PARAM_BIT   = 5;
    localparam int unsigned PCS_ERR_SUPPLY_BIT  = 7;

    // feedback byte 5 bit positions
    localparam int unsigned PCS_DIR_GATE_BIT   = 0;
    localparam int unsigned PCS_DIR_LEVEL_BIT  = 1;
    localparam int unsigned PCS_DIR_UP_BIT     = 6;
    localparam int unsigned PCS_DIR_DN_BIT     = 7;

    // feedback byte 6 bit positions
    localparam int unsigned PCS_EVT_SYNC_BIT   = 0;

    // reset values
    localparam logic [31:0] PCS_LOAD_RESET     = 32'h0000_0000;
    localparam logic [31:0] PCS_COUNT_RESET    = 32'h0000_0000;
    localparam logic [31:0] PCS_LATCH_RESET    = 32'h0000_0000;
    localparam logic [7:0]  PCS_BYTE_ZERO      = 8'h00;

    // function selected for the digital input
    typedef enum logic [2:0] {
        PCS_DI_INPUT     = 3'b000,
        PCS_DI_HW_GATE   = 3'b001,
        PCS_DI_LATCH     = 3'b010,
        PCS_DI_LATCH_RT  = 3'b011,
        PCS_DI_SYNC      = 3'b100,
        PCS_DI_SYNC_HWEN = 3'b101
    } pcs_di_func_t;

    // control image as written by the master
    typedef struct packed {
        logic [15:0] rsvd;        // bytes 6..7
        logic [7:0]  load_req;    // byte 5
        logic [7:0]  command;     // byte 4
        logic [31:0] value;       // bytes 0..3
    } pcs_ctl_t;

    // feedback image as read by the master
    typedef struct packed {
        logic [31:0] wide_count;  // bytes 8..11
        logic [7:0]  rsvd;        // byte 7
        logic [7:0]  event_bits;  // byte 6
        logic [7:0]  dir_bits;    // byte 5
        logic [7:0]  err_bits;    // byte 4
        logic [31:0] value;       // bytes 0..3
    } pcs_fb_t;

endpackage

// ===== rtl/pcs_edge_sync.sv
// two-flop synchroniser with rising edge detector for one pin
`timescale 1ns/10ps
`default_nettype none
module pcs_edge_sync (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic pin_in,
    output logic      level,
    output logic      rise
);
    logic meta;
    logic prev;

    // meta feeds only level; edge logic looks at level and prev
    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta  <= 1'b0;
            level <= 1'b0;
            prev  <= 1'b0;
        end else begin
            meta  <= pin_in;
            level <= meta;
            prev  <= level;
        end
    end

    // rising edge from two successive synchronised samples
    assign rise = level & ~prev;
endmodule
`default_nettype wire

// ===== rtl/pcs_sync_top.sv
// position counter with reference-edge sync and control/feedback images
//
// Contract
// - a rising reference edge sets the count to the held load value
// - a setting chooses once-only or periodic sync and the counter obeys it
// - reference edges cause no sync unless the software gate has opened counting; latching works with it closed
// - sync enable is control byte 4 bit 1; sync only while it is set
// - once-only mode: only the first edge after enabling reloads the count
// - periodic mode: every edge while enabled reloads the count
// - successful sync sets sticky feedback byte 6 bit 0 until status reset or until sync enable drops
// - feedback byte 5 bit 1 shows the live reference input level
// - isochronous: flag means a successful sync since the previous sample instant
// - byte groups 0-3, 4-7, 8-11 move as whole units, never partly updated
// - feedback bytes 0-3 carry the count, or the stored count under latch
// - feedback byte 4 holds error and load status; reserved bits read zero
// - feedback bytes 8-11 always carry the current count
// - control bytes 0-3 are the value; byte 5 bits request direct or staged load
// - control byte 4: bit 7 error ack, bit 2 status reset, bit 0 gate
// - sticky flags clear by handshake; device shows reset active on its ack bit
// - more than one load request at once sets load error and rejects the value
`timescale 1ns/10ps
`default_nettype none
module pcs_sync_top (
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    input  wire logic                  ctl_strobe,
    input  wire pcs_pkg::pcs_ctl_t     ctl_image,
    input  wire logic                  iso_mode,
    input  wire logic                  sample_instant,
    input  wire pcs_pkg::pcs_di_func_t di_function,
    input  wire logic                  sync_periodic,
    input  wire logic                  param_error,
    input  wire logic                  ref_input_pin,
    input  wire logic                  encoder_supply_short,
    input  wire logic                  count_up_pulse,
    input  wire logic                  count_dn_pulse,
    output pcs_pkg::pcs_fb_t           fb_image,
    output logic                       fb_update
);
    import pcs_pkg::*;

    // held control image, taken whole on each strobe
    pcs_ctl_t    ctl_hold;

    // counter state
    logic [31:0] count_value;
    logic [31:0] load_value;
    logic [31:0] latch_value;
    logic        gate_open;
    logic        gate_ctl_prev;
    logic        dir_up;
    logic        dir_dn;

    // sync state
    logic        sync_once_done;
    logic        sync_done_flag;
    logic        iso_sync_seen;

    // handshake and error state
    logic        flag_clear_ack;
    logic        load_error;
    logic        supply_error;
    logic        load_running;
    logic        imm_prev;
    logic        staged_prev;

    // synchronised pins
    logic        ref_input_level;
    logic        ref_rise;
    logic        supply_level;

    wire         soft_gate_ctl   = ctl_hold.command[PCS_CMD_GATE_BIT];
    wire         sync_enable     = ctl_hold.command[PCS_CMD_SYNC_BIT];
    wire         flag_clear_req  = ctl_hold.command[PCS_CMD_CLRREQ_BIT];
    wire         error_ack       = ctl_hold.command[PCS_CMD_ERRACK_BIT];
    wire         immediate_load_req = ctl_hold.load_req[PCS_REQ_IMM_BIT];
    wire         staged_load_req = ctl_hold.load_req[PCS_REQ_STAGED_BIT];

    // request edges, so a held request bit acts only once
    wire         imm_rise        = immediate_load_req & ~imm_prev;
    wire         staged_rise     = staged_load_req & ~staged_prev;
    wire         any_req_rise    = imm_rise | staged_rise;

    wire         req_conflict    = any_req_rise & immediate_load_req & staged_load_req;
    wire         do_imm_load     = imm_rise & ~req_conflict;
    wire         do_staged_load  = staged_rise & ~req_conflict;

    // input function decides whether sync applies at all
    wire         di_is_sync      = (di_function == PCS_DI_SYNC);
    wire         di_is_latch     = (di_function == PCS_DI_LATCH) |
                                   (di_function == PCS_DI_LATCH_RT);
    wire         di_is_retrig    = (di_function == PCS_DI_LATCH_RT);

    // sync armed only with gate open and enable set
    wire         sync_armed      = di_is_sync & sync_enable & gate_open;
    // once-only blocks after the first edge, periodic never blocks
    wire         sync_allowed    = sync_periodic | ~sync_once_done;
    wire         sync_event      = ref_rise & sync_armed & sync_allowed;

    // latch event; the input stays active even with the gate closed
    wire         latch_event     = ref_rise & di_is_latch;
    wire         retrig_event    = latch_event & di_is_retrig & gate_open;

    // counting step, a pulse in both directions cancels out
    wire         step_up         = gate_open & count_up_pulse & ~count_dn_pulse;
    wire         step_dn         = gate_open & count_dn_pulse & ~count_up_pulse;

    // feedback snapshot: every cycle, or only at the sample instant
    wire         fb_take         = ~iso_mode | sample_instant;

    // reference pin passes the synchroniser before use
    pcs_edge_sync u_ref_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pin_in   (ref_input_pin),
        .level    (ref_input_level),
        .rise     (ref_rise)
    );

    // supply fault pin, level only
    pcs_edge_sync u_supply_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pin_in   (encoder_supply_short),
        .level    (supply_level),
        .rise     ()
    );

    // step helper; the count rolls over at the 32-bit limits
    function automatic logic [31:0] pcs_step(input logic [31:0] cur,
                                             input logic        up,
                                             input logic        dn);
        logic [31:0] res;
        res = cur;
        if (up) begin
            res = cur + 32'h0000_0001;
        end else if (dn) begin
            res = cur - 32'h0000_0001;
        end
        return res;
    endfunction

    // control image taken as a whole, never byte by byte
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctl_hold <= '0;
        end else if (ctl_strobe) begin
            ctl_hold <= ctl_image;
        end
    end

    // edge memories of the control bits
    always_ff @(posedge core_clk) begin
        if (rst) begin
            gate_ctl_prev <= 1'b0;
            imm_prev      <= 1'b0;
            staged_prev   <= 1'b0;
        end else begin
            gate_ctl_prev <= soft_gate_ctl;
            imm_prev      <= immediate_load_req;
            staged_prev   <= staged_load_req;
        end
    end

    // software gate: opens only on a rising control bit, closes on a low bit
    always_ff @(posedge core_clk) begin
        if (rst) begin
            gate_open <= 1'b0;
        end else if (!soft_gate_ctl) begin
            gate_open <= 1'b0;
        end else if (!gate_ctl_prev) begin
            gate_open <= 1'b1;
        end
    end

    // staged load stores the value for later sync or load use
    always_ff @(posedge core_clk) begin
        if (rst) begin
            load_value <= PCS_LOAD_RESET;
        end else if (do_staged_load) begin
            load_value <= ctl_hold.value;
        end
    end

    // counter: direct load beats sync, sync beats counting
    always_ff @(posedge core_clk) begin
        if (rst) begin
            count_value <= PCS_COUNT_RESET;
        end else if (do_imm_load) begin
            count_value <= ctl_hold.value;
        end else if (sync_event || retrig_event) begin
            count_value <= load_value;
        end else begin
            count_value <= pcs_step(count_value, step_up, step_dn);
        end
    end

    // latch keeps the exact count at the edge; direct loads leave it alone
    always_ff @(posedge core_clk) begin
        if (rst) begin
            latch_value <= PCS_LATCH_RESET;
        end else if (latch_event) begin
            latch_value <= count_value;
        end
    end

    // direction status follows the last counted step
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dir_up <= 1'b0;
            dir_dn <= 1'b0;
        end else if (step_up) begin
            dir_up <= 1'b1;
            dir_dn <= 1'b0;
        end else if (step_dn) begin
            dir_up <= 1'b0;
            dir_dn <= 1'b1;
        end
    end

    // once marker cleared when enable drops, so re-enabling rearms
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sync_once_done <= 1'b0;
        end else if (!sync_enable) begin
            sync_once_done <= 1'b0;
        end else if (sync_event) begin
            sync_once_done <= 1'b1;
        end
    end

    // sticky sync flag; a new sync wins over a clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sync_done_flag <= 1'b0;
        end else if (sync_event) begin
            sync_done_flag <= 1'b1;
        end else if (flag_clear_req || !sync_enable) begin
            // cleared by handshake or enable drop
            sync_done_flag <= 1'b0;
        end
    end

    // acknowledge follows the request, showing reset active
    always_ff @(posedge core_clk) begin
        if (rst) begin
            flag_clear_ack <= 1'b0;
        end else begin
            flag_clear_ack <= flag_clear_req;
        end
    end

    // sync seen since the last sample instant, restarted at each instant
    always_ff @(posedge core_clk) begin
        if (rst) begin
            iso_sync_seen <= 1'b0;
        end else if (sample_instant) begin
            iso_sync_seen <= 1'b0;
        end else if (sync_event) begin
            iso_sync_seen <= 1'b1;
        end
    end

    // load error; new conflict wins over an acknowledge
    always_ff @(posedge core_clk) begin
        if (rst) begin
            load_error <= 1'b0;
        end else if (req_conflict) begin
            load_error <= 1'b1;
        end else if (error_ack) begin
            load_error <= 1'b0;
        end
    end

    // supply error holds until acknowledged with the short removed
    always_ff @(posedge core_clk) begin
        if (rst) begin
            supply_error <= 1'b0;
        end else if (supply_level) begin
            supply_error <= 1'b1;
        end else if (error_ack) begin
            supply_error <= 1'b0;
        end
    end

    // load running while an accepted request bit is still held
    always_ff @(posedge core_clk) begin
        if (rst) begin
            load_running <= 1'b0;
        end else if (do_imm_load || do_staged_load) begin
            load_running <= 1'b1;
        end else if (!immediate_load_req && !staged_load_req) begin
            load_running <= 1'b0;
        end
    end

    // feedback assembly; reserved bits are tied low
    pcs_fb_t     next_fb_image;
    logic        iso_sync_bit;

    // in isochronous mode report only edges of the closing window
    assign iso_sync_bit = iso_sync_seen | sync_event;

    always_comb begin
        next_fb_image = '0;
        // stored count under latch, running count otherwise
        next_fb_image.value = di_is_latch ? latch_value : count_value;
        next_fb_image.err_bits[PCS_ERR_SUPPLY_BIT]  = supply_error;
        next_fb_image.err_bits[PCS_ERR_PARAM_BIT]   = param_error;
        next_fb_image.err_bits[PCS_ERR_CLRACK_BIT]  = flag_clear_ack;
        next_fb_image.err_bits[PCS_ERR_LOADERR_BIT] = load_error;
        next_fb_image.err_bits[PCS_ERR_LOADRUN_BIT] = load_running;
        // direction and gate byte
        next_fb_image.dir_bits[PCS_DIR_DN_BIT]    = dir_dn;
        next_fb_image.dir_bits[PCS_DIR_UP_BIT]    = dir_up;
        next_fb_image.dir_bits[PCS_DIR_LEVEL_BIT] = ref_input_level;
        next_fb_image.dir_bits[PCS_DIR_GATE_BIT]  = gate_open;
        next_fb_image.event_bits[PCS_EVT_SYNC_BIT] = iso_mode ? iso_sync_bit : sync_done_flag;
        next_fb_image.rsvd = PCS_BYTE_ZERO;
        // wide bytes always carry the current count
        next_fb_image.wide_count = count_value;
    end

    // whole feedback image replaced in one edge
    always_ff @(posedge core_clk) begin
        if (rst) begin
            fb_image  <= '0;
            fb_update <= 1'b0;
        end else begin
            fb_update <= fb_take;
            if (fb_take) begin
                fb_image <= next_fb_image;
            end
        end
    end

endmodule
`default_nettype wire

// ===== sim/pcs_sync_sva.sv
// assertion checker for the position counter sync interface
`timescale 1ns/10ps
`default_nettype none
module pcs_sync_sva
    import pcs_pkg::*;
(
    input wire logic                  core_clk,
    input wire logic                  rst,
    input wire logic                  ctl_strobe,
    input wire pcs_pkg::pcs_ctl_t     ctl_image,
    input wire logic                  iso_mode,
    input wire logic                  sample_instant,
    input wire pcs_pkg::pcs_di_func_t di_function,
    input wire logic                  sync_periodic,
    input wire logic                  param_error,
    input wire logic                  ref_input_pin,
    input wire pcs_pkg::pcs_fb_t      fb_image,
    input wire logic                  fb_update
);
    pcs_ctl_t held;
    logic     armed;
    logic     clr_req;

    // shadow of the design's held control image
    always_ff @(posedge core_clk) begin
        if (rst) begin
            held <= '0;
        end else if (ctl_strobe) begin
            held <= ctl_image;
        end
    end

    // periodic sync enabled, no flag clear pending
    assign clr_req = held.command[PCS_CMD_CLRREQ_BIT];
    assign armed   = !iso_mode && sync_periodic && di_function == PCS_DI_SYNC
                     && held.command[1:0] == 2'b11 && !clr_req;

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    // reference rise, then four cycles for the sync path
    sequence s_ref_rise;
        armed && $rose(ref_input_pin) ##1 armed [*4];
    endsequence

    // both load requests rising, then three quiet cycles
    sequence s_double_load;
        ctl_strobe && !iso_mode && ctl_image.load_req[1:0] == 2'b11
        && held.load_req[1:0] == 2'b00 && !ctl_image.command[PCS_CMD_ERRACK_BIT]
        ##1 (!ctl_strobe && !iso_mode) [*3];
    endsequence

    a_sync_flag_set: assert property (
        s_ref_rise |-> fb_image.event_bits[PCS_EVT_SYNC_BIT])
        else $error("sync flag missing after reference edge");
    a_sync_needs_gate: assert property (
        $rose(fb_image.event_bits[PCS_EVT_SYNC_BIT]) && !iso_mode && $past(!iso_mode, 2)
        |-> $past(held.command[1:0] == 2'b11 && di_function == PCS_DI_SYNC, 2))
        else $error("sync flag rose without enable");
    a_level_report: assert property (
        (!iso_mode && $stable(ref_input_pin)) [*4]
        |-> fb_image.dir_bits[PCS_DIR_LEVEL_BIT] == ref_input_pin)
        else $error("level bit does not follow the pin");
    a_clear_ack: assert property (
        (!iso_mode && $stable(clr_req)) [*3]
        |-> fb_image.err_bits[PCS_ERR_CLRACK_BIT] == clr_req)
        else $error("clear ack does not follow the request");
    a_load_err_set: assert property (
        s_double_load |-> fb_image.err_bits[PCS_ERR_LOADERR_BIT])
        else $error("no load error on double request");
    a_param_err: assert property (
        (!iso_mode && $stable(param_error)) [*2]
        |-> fb_image.err_bits[PCS_ERR_PARAM_BIT] == param_error)
        else $error("parameter error bit wrong");
    a_reserved_zero: assert property (
        fb_image.rsvd == 8'h00 && fb_image.err_bits[6] == 1'b0
        && fb_image.err_bits[4:3] == 2'b00 && fb_image.dir_bits[5:2] == 4'h0
        && fb_image.event_bits[7:1] == 7'h00)
        else $error("reserved feedback bits not zero");
    a_wide_count: assert property (
        !iso_mode && $past(!iso_mode) && $past(di_function) inside {PCS_DI_INPUT, PCS_DI_SYNC}
        |-> fb_image.value == fb_image.wide_count)
        else $error("wide count differs from count");
    a_fb_refresh: assert property (
        !$past(rst) |-> fb_update == ($past(iso_mode) ? $past(sample_instant) : 1'b1))
        else $error("feedback refresh marker wrong");
    a_iso_frozen: assert property (
        iso_mode && !sample_instant && $past(!rst) |=> $stable(fb_image))
        else $error("feedback changed off instant");
endmodule

bind pcs_sync_top pcs_sync_sva u_sva (
    .core_clk(core_clk), .rst(rst), .ctl_strobe(ctl_strobe), .ctl_image(ctl_image),
    .iso_mode(iso_mode), .sample_instant(sample_instant), .di_function(di_function),
    .sync_periodic(sync_periodic), .param_error(param_error), .ref_input_pin(ref_input_pin),
    .fb_image(fb_image), .fb_update(fb_update)
);
`default_nettype wire

// ===== sim/pcs_master_model.sv
// fieldbus master model that writes whole control images
`timescale 1ns/10ps
`default_nettype none
module pcs_master_model
    import pcs_pkg::*;
(
    input  wire logic          core_clk,
    output var logic           ctl_strobe,
    output var pcs_pkg::pcs_ctl_t ctl_image
);
    initial begin
        ctl_strobe = 1'b0;
        ctl_image  = '0;
    end

    // one transfer carries the whole image, reserved bits zero
    task automatic send(input logic [7:0] cmd, input logic [7:0] req, input logic [31:0] val);
        @(negedge core_clk);
        ctl_image  = '{rsvd: 16'h0000, load_req: req & 8'h03, command: cmd & 8'h87, value: val};
        ctl_strobe = 1'b1;
        @(negedge core_clk);
        ctl_strobe = 1'b0;
        // show junk once the image is unqualified
        ctl_image  = ~ctl_image;
        repeat (3) @(negedge core_clk);
    endtask
endmodule
`default_nettype wire

// ===== sim/test_position_counter_sync_interface.sv
// self-checking bench for the position counter sync interface
`timescale 1ns/10ps
`default_nettype none
module test_position_counter_sync_interface;
    import pcs_pkg::*;
    logic         core_clk, rst, ctl_strobe, iso_mode, sample_instant, sync_periodic;
    logic         param_error, ref_input_pin, encoder_supply_short, fb_update;
    logic         count_up_pulse, count_dn_pulse;
    pcs_ctl_t     ctl_image;
    pcs_fb_t      fb_image;
    pcs_di_func_t di_function;
    pcs_di_func_t no_sync[3] = '{PCS_DI_INPUT, PCS_DI_HW_GATE, PCS_DI_SYNC_HWEN};
    int           n_mismatch = 0;
    int           check_count = 0;
    logic [31:0]  rnd_state = 32'h0000_9ebe;
    logic [31:0]  exp_count, exp_load, tmp;

    pcs_master_model master (.core_clk(core_clk), .ctl_strobe(ctl_strobe), .ctl_image(ctl_image));
    pcs_sync_top uut (
        .core_clk(core_clk), .rst(rst), .ctl_strobe(ctl_strobe), .ctl_image(ctl_image),
        .iso_mode(iso_mode), .sample_instant(sample_instant), .di_function(di_function),
        .sync_periodic(sync_periodic), .param_error(param_error),
        .ref_input_pin(ref_input_pin), .encoder_supply_short(encoder_supply_short),
        .count_up_pulse(count_up_pulse), .count_dn_pulse(count_dn_pulse),
        .fb_image(fb_image), .fb_update(fb_update));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    function automatic logic [31:0] xrnd();
        rnd_state = rnd_state ^ (rnd_state << 13);
        rnd_state = rnd_state ^ (rnd_state >> 17);
        rnd_state = rnd_state ^ (rnd_state << 5);
        return rnd_state;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
            n_mismatch++;
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic cmp_count();
        chk(fb_image.value, exp_count);
        chk(fb_image.wide_count, exp_count);
    endtask

    // pulse kept well above the three-cycle edge spacing
    task automatic ref_edge(input logic look);
        ref_input_pin = 1'b1;
        cyc(5);
        if (look) chk(32'(fb_image.dir_bits[PCS_DIR_LEVEL_BIT]), 32'h1);
        ref_input_pin = 1'b0;
        cyc(5);
        if (look) chk(32'(fb_image.dir_bits[PCS_DIR_LEVEL_BIT]), 32'h0);
    endtask

    // spaced count steps; the model wraps at 32 bits
    task automatic step(input int n, input logic up);
        repeat (n) begin
            count_up_pulse = up;
            count_dn_pulse = !up;
            cyc(1);
            count_up_pulse = 1'b0;
            count_dn_pulse = 1'b0;
            cyc(1);
            exp_count = up ? exp_count + 32'd1 : exp_count - 32'd1;
        end
        cyc(3);
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (20000) @(posedge core_clk);
        $display("MISMATCH t=%0t run did not finish", $time);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        {rst, iso_mode, sample_instant, sync_periodic, param_error} = 5'b10000;
        {ref_input_pin, encoder_supply_short, count_up_pulse, count_dn_pulse} = 4'h0;
        di_function = PCS_DI_SYNC;
        exp_count = 32'h0;
        exp_load = 32'h0;
        cyc(8);
        rst = 1'b0;
        cyc(1);
        chk(fb_image[31:0], 32'h0);
        chk(32'(fb_image.event_bits), 32'h0);
        master.send(8'h01, 8'h00, 32'h0);
        chk(32'(fb_image.dir_bits[PCS_DIR_GATE_BIT]), 32'h1);
        exp_load = xrnd();
        master.send(8'h01, 8'h02, exp_load);
        cmp_count();
        chk(32'(fb_image.err_bits), 32'h01);
        tmp = xrnd();
        master.send(8'h01, 8'h00, tmp);
        master.send(8'h01, 8'h01, tmp);
        exp_count = tmp;
        cmp_count();
        master.send(8'h01, 8'h00, tmp);
        step(int'(xrnd() % 32'd8) + 1, 1'b1);
        step(3, 1'b0);
        chk(32'(fb_image.dir_bits), 32'h81);
        cmp_count();
        done("load and count");
        sync_periodic = 1'b1;
        master.send(8'h03, 8'h00, 32'h0);
        repeat (2) begin
            ref_edge(1'b1);
            exp_count = exp_load;
            cmp_count();
            chk(32'(fb_image.event_bits), 32'h01);
            step(4, 1'b1);
        end
        master.send(8'h07, 8'h00, 32'h0);
        chk(32'(fb_image.err_bits), 32'h04);
        chk(32'(fb_image.event_bits), 32'h00);
        master.send(8'h03, 8'h00, 32'h0);
        chk(32'(fb_image.err_bits), 32'h00);
        done("periodic sync and clear");
        sync_periodic = 1'b0;
        master.send(8'h01, 8'h00, 32'h0);
        master.send(8'h03, 8'h00, 32'h0);
        ref_edge(1'b0);
        exp_count = exp_load;
        step(2, 1'b1);
        ref_edge(1'b0);
        cmp_count();
        master.send(8'h06, 8'h00, 32'h0);
        master.send(8'h02, 8'h00, 32'h0);
        sync_periodic = 1'b1;
        ref_edge(1'b0);
        cmp_count();
        chk(32'(fb_image.event_bits), 32'h00);
        master.send(8'h03, 8'h00, 32'h0);
        foreach (no_sync[i]) begin
            di_function = no_sync[i];
            ref_edge(1'b0);
            cmp_count();
            chk(32'(fb_image.event_bits), 32'h00);
        end
        di_function = PCS_DI_LATCH;
        tmp = exp_count;
        ref_edge(1'b0);
        step(2, 1'b1);
        chk(fb_image.value, tmp);
        chk(fb_image.wide_count, exp_count);
        di_function = PCS_DI_LATCH_RT;
        ref_edge(1'b0);
        chk(fb_image.value, exp_count);
        exp_count = exp_load;
        chk(fb_image.wide_count, exp_count);
        done("sync limits and latches");
        di_function = PCS_DI_SYNC;
        master.send(8'h01, 8'h03, xrnd());
        chk(32'(fb_image.err_bits), 32'h02);
        chk(fb_image.wide_count, exp_count);
        master.send(8'h01, 8'h00, 32'h0);
        chk(32'(fb_image.err_bits), 32'h02);
        master.send(8'h81, 8'h00, 32'h0);
        master.send(8'h01, 8'h00, 32'h0);
        chk(32'(fb_image.err_bits), 32'h00);
        {encoder_supply_short, param_error} = 2'b11;
        cyc(5);
        chk(32'(fb_image.err_bits), 32'ha0);
        master.send(8'h81, 8'h00, 32'h0);
        chk(32'(fb_image.err_bits), 32'ha0);
        {encoder_supply_short, param_error} = 2'b00;
        cyc(5);
        chk(32'(fb_image.err_bits), 32'h00);
        done("errors");
        master.send(8'h03, 8'h00, 32'h0);
        iso_mode = 1'b1;
        cyc(2);
        ref_edge(1'b0);
        chk(32'(fb_image.event_bits), 32'h00);
        exp_count = exp_load;
        sample_instant = 1'b1;
        cyc(1);
        sample_instant = 1'b0;
        cyc(2);
        chk(32'(fb_image.event_bits), 32'h01);
        cmp_count();
        done("isochronous");
        wrap_up();
    end
endmodule
`default_nettype wire
